//--- hw/pcg_pkg.sv
// Constants, register map and types shared by the clock generator control design.
package pcg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned SYS_CLK_MHZ = 100;
	localparam int unsigned LOCK_TIME_US = 300;
	localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * SYS_CLK_MHZ;
	localparam int unsigned LOCK_W = 16;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_LOCK = 8'h00;
	localparam logic [7:0] ADDR_MAIN = 8'h04;
	localparam logic [7:0] ADDR_USB = 8'h08;
	localparam logic [7:0] ADDR_DIV = 8'h0C;
	localparam logic [7:0] ADDR_SLOW = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam int unsigned PLL_M_LSB = 12;
	localparam int unsigned PLL_P_LSB = 4;
	localparam int unsigned PLL_S_LSB = 0;
	localparam logic [8:0] PLL_M_OFS = 9'h008;
	localparam logic [6:0] PLL_P_OFS = 7'h02;
	localparam logic [31:0] MAIN_CFG_RST = 32'h00050010;
	localparam logic [31:0] USB_CFG_RST = 32'h00030010;
	localparam int unsigned DIV_PSEL_BIT = 0;
	localparam int unsigned DIV_HSEL_LSB = 1;
	localparam int unsigned DIV_QHALF_BIT = 8;
	localparam int unsigned DIV_THALF_BIT = 9;
	localparam logic [9:0] DIV_RST = 10'h000;
	localparam int unsigned SLOW_USB_OFF_BIT = 7;
	localparam int unsigned RATIO_W = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {CORE_OFF, CORE_REF, CORE_PLL} pcg_core_mode_t;

endpackage

//--- hw/pcg_ratio_div.sv
// Glitch-free integer divider of a sampled clock level.
`timescale 1ns/1ps
module pcg_ratio_div
	import pcg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Source and ratio
	input wire logic src_i,
	input wire logic [RATIO_W-1:0] ratio_i,
	// Divided clock
	output logic clk_o
);

	logic src_prev_q;
	logic [RATIO_W-1:0] cnt_q;
	logic [RATIO_W-1:0] cnt_d;
	logic [RATIO_W-1:0] ratio_q;
	logic rise;

	assign rise = src_i & ~src_prev_q;
	assign cnt_d = (cnt_q >= ratio_q - RATIO_W'(1)) ? '0 : cnt_q + RATIO_W'(1);

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= src_i;
		end
	end

	// A new ratio is taken only at the end of a whole output period.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q <= '0;
			ratio_q <= RATIO_W'(1);
		end else if (rise) begin
			cnt_q <= cnt_d;
			if (cnt_d == '0) begin
				ratio_q <= ratio_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_o <= 1'b0;
		end else if (ratio_q == RATIO_W'(1)) begin
			clk_o <= src_i;
		end else if (rise) begin
			clk_o <= (cnt_d < (ratio_q >> 1));
		end
	end

endmodule

//--- hw/pcg_clock_ctrl.sv
// Clock generator control: boot source latch, PLL lock timing, clock muxes and ratios.
`timescale 1ns/1ps

// Functional notes
// - Latch boot clock-select pins at reset release.
// - Latched bits pick main and USB sources.
// - Boot mode 11 makes select bits test mode.
// - Core runs from reference until main config written.
// - Main PLL output follows M+8, P+2, S formula.
// - Core clock off during lock, reset, wakeup.
// - Main PLL runs default configuration after reset.
// - Lock restarts on write; then core uses PLL.
// - Divider write during lock waits; applied at lock end.
// - USB clock: reference, low during lock, then PLL.
// - Slow control USB PLL off gives reference clock.
// - Bus select 0/1 with peripheral select ratios.
// - Bus select 3 and 2 with halve bits.
// - Divider applies after lock, reset, power-mode change.
// - Divider change outside lock takes about one bus period.
// - Lock interval counted from programmable count register.
module pcg_clock_ctrl
	import pcg_pkg::*;
#(
	parameter logic [LOCK_W-1:0] LOCK_RESET = LOCK_W'(LOCK_CYCLES)
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Pins and sources
	input wire logic reset_n_pin_i,
	input wire logic boot_clock_select_hi_i,
	input wire logic boot_clock_select_lo_i,
	input wire logic [1:0] boot_mode_pins_i,
	input wire logic crystal_input_i,
	input wire logic external_clock_input_i,
	input wire logic main_pll_clk_i,
	input wire logic usb_pll_clk_i,
	// Power management events
	input wire logic wakeup_i,
	input wire logic power_mode_change_i,
	// Clock outputs
	output logic core_clock_o,
	output logic bus_clock_o,
	output logic periph_clock_o,
	output logic usb_clock_o,
	// PLL settings to the analog macros and test mode outputs
	output logic [8:0] main_pll_m_o,
	output logic [6:0] main_pll_p_o,
	output logic [1:0] main_pll_s_o,
	output logic [8:0] usb_pll_m_o,
	output logic [6:0] usb_pll_p_o,
	output logic [1:0] usb_pll_s_o,
	output logic usb_pll_on_o,
	output logic test_mode_o,
	output logic [1:0] test_mode_sel_o,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	// ****************************************
	// Declarations
	// ****************************************
	logic rst_pin_prev_q;
	logic [1:0] boot_sel_q;
	logic boot_test_q;
	logic [LOCK_W-1:0] lock_time_q;
	logic [31:0] main_cfg_q;
	logic [31:0] usb_cfg_q;
	logic [9:0] div_cfg_q;
	logic [9:0] div_act_q;
	logic [31:0] slow_q;
	logic main_written_q;
	logic usb_written_q;
	logic [LOCK_W-1:0] main_lock_q;
	logic [LOCK_W-1:0] usb_lock_q;
	pcg_core_mode_t core_mode_q;
	pcg_core_mode_t core_mode_d;
	logic mode_ok;
	logic cur_low;
	logic main_ref;
	logic usb_ref;
	logic main_locking;
	logic main_lock_end;
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] wmask;
	logic wr_go;
	logic wr_main;
	logic wr_usb;
	logic wr_div;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [RATIO_W-1:0] bus_ratio;
	logic [RATIO_W-1:0] per_ratio;

	// ****************************************
	// Boot clock-select latch
	// ****************************************
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rst_pin_prev_q <= 1'b0;
			boot_sel_q <= 2'h0;
			boot_test_q <= 1'b0;
		end else begin
			rst_pin_prev_q <= reset_n_pin_i;
			if (reset_n_pin_i && !rst_pin_prev_q) begin
				boot_sel_q <= {boot_clock_select_hi_i, boot_clock_select_lo_i};
				boot_test_q <= &boot_mode_pins_i;
			end
		end
	end

	// In test mode the select bits do not pick sources; the crystal drives both.
	assign main_ref = (!boot_test_q && boot_sel_q[1]) ? external_clock_input_i
		: crystal_input_i;
	assign usb_ref = (!boot_test_q && boot_sel_q[0]) ? external_clock_input_i
		: crystal_input_i;
	assign test_mode_o = boot_test_q;
	assign test_mode_sel_o = boot_test_q ? boot_sel_q : 2'h0;

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	assign s_axi_awready_o = !aw_have_q && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_have_q && !s_axi_bvalid_o;
	assign wr_go = aw_have_q && w_have_q;
	assign wr_main = wr_go && (awaddr_q == ADDR_MAIN);
	assign wr_usb = wr_go && (awaddr_q == ADDR_USB);
	assign wr_div = wr_go && (awaddr_q == ADDR_DIV);

	generate
		for (genvar b = 0; b < 4; b++) begin : g_mask
			assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
		end
	endgenerate

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= ADDR_SLOW) ? RESP_OKAY
					: RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Writing the same value still counts: any write to a PLL config starts a lock.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lock_time_q <= LOCK_RESET;
			main_cfg_q <= MAIN_CFG_RST;
			usb_cfg_q <= USB_CFG_RST;
			div_cfg_q <= DIV_RST;
			slow_q <= 32'h00000000;
		end else if (wr_go) begin
			case (awaddr_q)
				ADDR_LOCK: lock_time_q <= (lock_time_q & ~wmask[LOCK_W-1:0])
					| (wdata_q[LOCK_W-1:0] & wmask[LOCK_W-1:0]);
				ADDR_MAIN: main_cfg_q <= (main_cfg_q & ~wmask) | (wdata_q & wmask);
				ADDR_USB: usb_cfg_q <= (usb_cfg_q & ~wmask) | (wdata_q & wmask);
				ADDR_DIV: div_cfg_q <= (div_cfg_q & ~wmask[9:0]) | (wdata_q[9:0] & wmask[9:0]);
				ADDR_SLOW: slow_q <= (slow_q & ~wmask) | (wdata_q & wmask);
				default: ;
			endcase
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		case (s_axi_araddr_i)
			ADDR_LOCK: rd_data = 32'(lock_time_q);
			ADDR_MAIN: rd_data = main_cfg_q;
			ADDR_USB: rd_data = usb_cfg_q;
			ADDR_DIV: rd_data = 32'(div_cfg_q);
			ADDR_SLOW: rd_data = slow_q;
			ADDR_STAT: rd_data = {24'h000000, main_locking, usb_lock_q != '0,
				core_mode_q == CORE_PLL, usb_written_q, main_written_q, boot_test_q, boot_sel_q};
			default: rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_data;
			s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ****************************************
	// PLL settings
	// ****************************************
	assign main_pll_m_o = 9'(main_cfg_q[PLL_M_LSB +: 8]) + PLL_M_OFS;
	assign main_pll_p_o = 7'(main_cfg_q[PLL_P_LSB +: 6]) + PLL_P_OFS;
	assign main_pll_s_o = main_cfg_q[PLL_S_LSB +: 2];
	assign usb_pll_m_o = 9'(usb_cfg_q[PLL_M_LSB +: 8]) + PLL_M_OFS;
	assign usb_pll_p_o = 7'(usb_cfg_q[PLL_P_LSB +: 6]) + PLL_P_OFS;
	assign usb_pll_s_o = usb_cfg_q[PLL_S_LSB +: 2];
	assign usb_pll_on_o = !slow_q[SLOW_USB_OFF_BIT];

	// ****************************************
	// Lock timers
	// ****************************************
	assign main_locking = (main_lock_q != '0);
	assign main_lock_end = (main_lock_q == LOCK_W'(1));

	// The timer starts loaded, so power-on reset also waits one lock time.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			main_lock_q <= LOCK_RESET;
			main_written_q <= 1'b0;
		end else begin
			if (wr_main) begin
				main_lock_q <= lock_time_q;
				main_written_q <= 1'b1;
			end else if (wakeup_i) begin
				main_lock_q <= lock_time_q;
			end else if (main_locking) begin
				main_lock_q <= main_lock_q - LOCK_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			usb_lock_q <= '0;
			usb_written_q <= 1'b0;
		end else if (wr_usb) begin
			usb_lock_q <= lock_time_q;
			usb_written_q <= 1'b1;
		end else if (usb_lock_q != '0) begin
			usb_lock_q <= usb_lock_q - LOCK_W'(1);
		end
	end

	// ****************************************
	// Core clock source
	// ****************************************
	always_comb begin
		if (main_locking) begin
			core_mode_d = CORE_OFF;
		end else if (main_written_q) begin
			core_mode_d = CORE_PLL;
		end else begin
			core_mode_d = CORE_REF;
		end
		case (core_mode_d)
			CORE_OFF: mode_ok = 1'b1;
			CORE_REF: mode_ok = !main_ref;
			CORE_PLL: mode_ok = !main_pll_clk_i;
			default: mode_ok = 1'b1;
		endcase
		case (core_mode_q)
			CORE_OFF: cur_low = 1'b1;
			CORE_REF: cur_low = !main_ref;
			CORE_PLL: cur_low = !main_pll_clk_i;
			default: cur_low = 1'b1;
		endcase
	end

	// A switch waits until the current source is low, so the output never launches a
	// clipped high pulse; leaving a low output for a running source also needs the new
	// source low, so no low phase is clipped either.
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			core_mode_q <= CORE_OFF;
		end else if (cur_low && mode_ok && (!core_clock_o || core_mode_d == CORE_OFF)) begin
			core_mode_q <= core_mode_d;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			core_clock_o <= 1'b0;
		end else begin
			case (core_mode_q)
				CORE_OFF: core_clock_o <= 1'b0;
				CORE_REF: core_clock_o <= main_ref;
				CORE_PLL: core_clock_o <= main_pll_clk_i;
				default: core_clock_o <= 1'b0;
			endcase
		end
	end

	// ****************************************
	// USB clock
	// ****************************************
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			usb_clock_o <= 1'b0;
		end else if (slow_q[SLOW_USB_OFF_BIT] || !usb_written_q) begin
			usb_clock_o <= usb_ref;
		end else if (usb_lock_q != '0) begin
			usb_clock_o <= 1'b0;
		end else begin
			usb_clock_o <= usb_pll_clk_i;
		end
	end

	// ****************************************
	// Divider ratios
	// ****************************************
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_act_q <= DIV_RST;
		end else if ((wr_div && !main_locking) || main_lock_end || power_mode_change_i) begin
			div_act_q <= wr_div ? ((div_cfg_q & ~wmask[9:0]) | (wdata_q[9:0] & wmask[9:0]))
				: div_cfg_q;
		end
	end

	always_comb begin
		case (div_act_q[DIV_HSEL_LSB +: 2])
			2'h0: bus_ratio = RATIO_W'(1);
			2'h1: bus_ratio = RATIO_W'(2);
			2'h3: bus_ratio = div_act_q[DIV_THALF_BIT] ? RATIO_W'(6) : RATIO_W'(3);
			2'h2: bus_ratio = div_act_q[DIV_QHALF_BIT] ? RATIO_W'(8) : RATIO_W'(4);
			default: bus_ratio = RATIO_W'(1);
		endcase
		per_ratio = div_act_q[DIV_PSEL_BIT] ? RATIO_W'(bus_ratio << 1) : bus_ratio;
	end

	pcg_ratio_div u_bus_div (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.src_i(core_clock_o),
		.ratio_i(bus_ratio),
		.clk_o(bus_clock_o)
	);

	pcg_ratio_div u_per_div (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.src_i(core_clock_o),
		.ratio_i(per_ratio),
		.clk_o(periph_clock_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	chk_boot_latch: assert property (reset_n_pin_i && !rst_pin_prev_q |=>
		boot_sel_q == $past({boot_clock_select_hi_i, boot_clock_select_lo_i}))
		else $error("boot select not latched");
	chk_ref_before_cfg: assert property (!main_written_q |-> core_mode_q != CORE_PLL)
		else $error("core on PLL before config write");
	chk_lock_load: assert property (wr_main |=> main_lock_q == $past(lock_time_q))
		else $error("lock timer not loaded");
	chk_core_gated: assert property (main_locking && core_mode_q == CORE_OFF |=>
		!core_clock_o) else $error("core clock during lock");
	chk_pll_after_lock: assert property (main_lock_end && main_written_q && !wr_main
		&& !wakeup_i |-> ##[1:8] core_mode_q == CORE_PLL)
		else $error("core not on PLL after lock");
	chk_usb_low_lock: assert property (usb_lock_q > LOCK_W'(1) && !slow_q[SLOW_USB_OFF_BIT]
		|=> !usb_clock_o) else $error("usb clock during lock");
	chk_div_hold: assert property (main_locking && !main_lock_end && !power_mode_change_i
		|=> $stable(div_act_q)) else $error("divider changed during lock");
	chk_m_formula: assert property (
		main_pll_m_o - PLL_M_OFS == 9'(main_cfg_q[PLL_M_LSB +: 8]))
		else $error("main M setting wrong");
	chk_div_power: assert property (power_mode_change_i && !wr_div |=>
		div_act_q == $past(div_cfg_q)) else $error("divider not applied on power change");
	chk_no_short_high: assert property ($rose(core_clock_o) |->
		core_mode_q == $past(core_mode_q)) else $error("core mode switched mid phase");
	chk_bresp_time: assert property (s_axi_wvalid_i && s_axi_wready_o && s_axi_awvalid_i
		&& s_axi_awready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");

	cov_main_cfg: cover property (wr_main ##[1:1000] core_mode_q == CORE_PLL);
	cov_usb_pll: cover property (usb_written_q && usb_lock_q == '0 && usb_clock_o);
	cov_div_max: cover property (per_ratio == RATIO_W'(16));

endmodule

//--- tb/testbench.sv
// Self-checking testbench for the clock generator control block.
`timescale 1ns/1ps
module testbench
	import pcg_pkg::*;
;
	localparam int L0 = 20;
	localparam int L1 = 40;
	localparam int WIN = 384;

	// ****************************************
	// Design signals
	// ****************************************
	logic sys_clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic reset_n_pin_i = 1'h0;
	logic boot_clock_select_hi_i = 1'h0;
	logic boot_clock_select_lo_i = 1'h0;
	logic [1:0] boot_mode_pins_i = 2'h0;
	logic crystal_input_i = 1'h0;
	logic external_clock_input_i = 1'h0;
	logic main_pll_clk_i = 1'h0;
	logic usb_pll_clk_i = 1'h0;
	logic wakeup_i = 1'h0;
	logic power_mode_change_i = 1'h0;
	logic core_clock_o, bus_clock_o, periph_clock_o, usb_clock_o;
	logic [8:0] main_pll_m_o, usb_pll_m_o;
	logic [6:0] main_pll_p_o, usb_pll_p_o;
	logic [1:0] main_pll_s_o, usb_pll_s_o;
	logic usb_pll_on_o, test_mode_o;
	logic [1:0] test_mode_sel_o;
	logic [7:0] s_axi_awaddr_i = 8'h00;
	logic s_axi_awvalid_i = 1'h0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_wvalid_i = 1'h0;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_bready_i = 1'h0;
	logic [7:0] s_axi_araddr_i = 8'h00;
	logic s_axi_arvalid_i = 1'h0;
	logic s_axi_arready_o, s_axi_rvalid_o;
	logic [31:0] s_axi_rdata_o;
	logic s_axi_rready_i = 1'h0;

	int n_errors = 0;
	int num_checks = 0;
	int cnt [4];
	int run;
	logic [31:0] rd;
	logic [3:0] ext_q = 4'h0;
	logic [2:0] cyc_q = 3'h0;
	logic [1:0] hs [12] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2};
	logic th [12] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
	logic qh [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
	int bd [12] = '{1, 1, 2, 2, 3, 3, 6, 6, 4, 4, 8, 8};
	int pd [12] = '{1, 2, 2, 4, 3, 6, 6, 12, 4, 8, 8, 16};
	logic [7:0] ra [5] = '{ADDR_LOCK, ADDR_MAIN, ADDR_USB, ADDR_DIV, ADDR_SLOW};
	logic [31:0] rv [5] = '{32'h14, MAIN_CFG_RST, USB_CFG_RST, 32'h0, 32'h0};

	// ****************************************
	// Clocks and sources
	// ****************************************
	always #5 sys_clk_i = ~sys_clk_i;

	// Crystal period 8, external period 12, main PLL period 2, USB PLL period 4 cycles.
	always @(posedge sys_clk_i) begin
		cyc_q <= cyc_q + 3'h1;
		ext_q <= (ext_q == 4'hB) ? 4'h0 : ext_q + 4'h1;
		crystal_input_i <= cyc_q[2];
		usb_pll_clk_i <= cyc_q[1];
		main_pll_clk_i <= ~main_pll_clk_i;
		external_clock_input_i <= (ext_q > 4'h5);
	end

	pcg_clock_ctrl #(.LOCK_RESET(16'h0014)) i_dut (
		.sys_clk_i, .reset_i, .reset_n_pin_i, .boot_clock_select_hi_i, .boot_clock_select_lo_i,
		.boot_mode_pins_i, .crystal_input_i, .external_clock_input_i, .main_pll_clk_i,
		.usb_pll_clk_i, .wakeup_i, .power_mode_change_i, .core_clock_o, .bus_clock_o,
		.periph_clock_o, .usb_clock_o, .main_pll_m_o, .main_pll_p_o, .main_pll_s_o,
		.usb_pll_m_o, .usb_pll_p_o, .usb_pll_s_o, .usb_pll_on_o, .test_mode_o, .test_mode_sel_o,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic sig(input int i);
		case (i)
			0: return core_clock_o;
			1: return bus_clock_o;
			2: return periph_clock_o;
			default: return usb_clock_o;
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic near(input int seen, input int lo, input int hi, input string msg);
		num_checks++;
		if (seen < lo || seen > hi) begin
			n_errors++;
			$display("[FAIL] %0t %s: seen %0d outside %0d..%0d", $time, msg, seen, lo, hi);
		end
	endtask

	// Counts rising edges of core, bus, peripheral and USB clocks over one window.
	task automatic measure();
		logic [3:0] prev;
		prev = {usb_clock_o, periph_clock_o, bus_clock_o, core_clock_o};
		for (int i = 0; i < 4; i++) cnt[i] = 0;
		repeat (WIN) begin
			@(posedge sys_clk_i);
			for (int i = 0; i < 4; i++) begin
				if (sig(i) === 1'h1 && prev[i] === 1'h0) cnt[i]++;
				prev[i] = sig(i);
			end
		end
	endtask

	// Longest stretch of low level on one clock output within 80 cycles.
	task automatic zero_run(input int i, output int r);
		int cur;
		cur = 0;
		r = 0;
		repeat (80) begin
			@(posedge sys_clk_i);
			cur = (sig(i) === 1'h0) ? cur + 1 : 0;
			if (cur > r) r = cur;
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		@(posedge sys_clk_i);
		aw_done = 1'h0;
		w_done = 1'h0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge sys_clk_i);
			if (!aw_done && s_axi_awready_o === 1'h1) begin
				aw_done = 1'h1;
				s_axi_awvalid_i <= 1'h0;
			end
			if (!w_done && s_axi_wready_o === 1'h1) begin
				w_done = 1'h1;
				s_axi_wvalid_i <= 1'h0;
			end
		end
		do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'h1);
		s_axi_bready_i <= 1'h0;
		check(s_axi_bresp_o, er, "write response");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'h1);
		s_axi_arvalid_i <= 1'h0;
		do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'h1);
		s_axi_rready_i <= 1'h0;
		d = s_axi_rdata_o;
		check(s_axi_rresp_o, er, "read response");
	endtask

	// Boot pins are inverted once captured, so a later read shows what was held.
	task automatic do_reset(input logic hi, input logic lo, input logic [1:0] mode);
		@(posedge sys_clk_i);
		reset_i <= 1'h1;
		reset_n_pin_i <= 1'h0;
		boot_clock_select_hi_i <= hi;
		boot_clock_select_lo_i <= lo;
		boot_mode_pins_i <= mode;
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'h0;
		@(posedge sys_clk_i);
		reset_n_pin_i <= 1'h1;
		@(posedge sys_clk_i);
		boot_clock_select_hi_i <= ~hi;
		boot_clock_select_lo_i <= ~lo;
		boot_mode_pins_i <= ~mode;
	endtask

	task automatic complete_run();
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		do_reset(1'h1, 1'h0, 2'h0);
		zero_run(0, run);
		near(run, L0 - 4, L0 + 6, "core gated after reset");
		measure();
		near(cnt[0], 31, 33, "core from external reference");
		near(cnt[3], 47, 49, "usb from crystal");
		for (int i = 0; i < 5; i++) begin
			axi_rd(ra[i], rd, RESP_OKAY);
			check(rd, rv[i], "register reset value");
		end
		check(main_pll_m_o, 9'h058, "main m");
		check(main_pll_p_o, 7'h03, "main p");
		check(main_pll_s_o, 2'h0, "main s");
		check(usb_pll_m_o, 9'h038, "usb m");
		check(usb_pll_p_o, 7'h03, "usb p");
		check(usb_pll_s_o, 2'h0, "usb s");
		axi_rd(8'h20, rd, RESP_SLVERR);
		check(rd, 32'h0, "unmapped read data");
		axi_wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
		axi_wr(8'h06, 32'hFFFFFFFF, RESP_SLVERR);
		axi_wr(ADDR_STAT, 32'hFFFFFFFF, RESP_SLVERR);
		axi_rd(ADDR_STAT, rd, RESP_OKAY);
		check(rd[2:0], 3'h2, "latched boot select");
		axi_wr(ADDR_LOCK, L1, RESP_OKAY);
		fork
			zero_run(3, run);
			axi_wr(ADDR_USB, USB_CFG_RST, RESP_OKAY);
		join
		near(run, L1 - 4, L1 + 10, "usb low during lock");
		measure();
		near(cnt[3], 95, 97, "usb from pll");
		axi_wr(ADDR_SLOW, 32'h80, RESP_OKAY);
		check(usb_pll_on_o, 1'h0, "usb pll off");
		repeat (20) @(posedge sys_clk_i);
		measure();
		near(cnt[3], 47, 49, "usb back to reference");
		axi_wr(ADDR_SLOW, 32'h0, RESP_OKAY);
		check(usb_pll_on_o, 1'h1, "usb pll on");
		repeat (60) @(posedge sys_clk_i);
		measure();
		near(cnt[3], 95, 97, "usb pll again");
		fork
			zero_run(0, run);
			begin
				axi_wr(ADDR_MAIN, 32'h0007F052, RESP_OKAY);
				axi_wr(ADDR_DIV, 32'h3, RESP_OKAY);
			end
		join
		near(run, L1 - 4, L1 + 10, "core gated during lock");
		check(main_pll_m_o, 9'h087, "new main m");
		check(main_pll_p_o, 7'h07, "new main p");
		check(main_pll_s_o, 2'h2, "new main s");
		repeat (40) @(posedge sys_clk_i);
		measure();
		near(cnt[0], 191, 193, "core from main pll");
		near(cnt[1], 95, 97, "bus after lock");
		near(cnt[2], 47, 49, "periph after lock");
		axi_rd(ADDR_STAT, rd, RESP_OKAY);
		check(rd[5], 1'h1, "core on pll flag");
		@(posedge sys_clk_i);
		wakeup_i <= 1'h1;
		power_mode_change_i <= 1'h1;
		@(posedge sys_clk_i);
		wakeup_i <= 1'h0;
		power_mode_change_i <= 1'h0;
		zero_run(0, run);
		near(run, L1 - 4, L1 + 10, "core gated at wakeup");
		for (int i = 0; i < 12; i++) begin
			axi_wr(ADDR_DIV, {22'h0, th[i], qh[i], 5'h0, hs[i], i[0]}, RESP_OKAY);
			repeat (40) @(posedge sys_clk_i);
			measure();
			near(cnt[1], 192 / bd[i] - 1, 192 / bd[i] + 1, "bus ratio");
			near(cnt[2], 192 / pd[i] - 1, 192 / pd[i] + 1, "periph ratio");
		end
		do_reset(1'h0, 1'h1, 2'h3);
		axi_rd(ADDR_STAT, rd, RESP_OKAY);
		check(rd[2:0], 3'h5, "test mode status");
		check(test_mode_o, 1'h1, "test mode flag");
		check(test_mode_sel_o, 2'h1, "test mode select");
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge sys_clk_i);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end
endmodule
